/* File: verilog/adc_ctrl_pkg.sv */
// Summary of operation
// - busy bit 7 set at start, cleared end/abort
// - software trigger: start on control-one write
// - hardware trigger: start on trigger input
// - bit 5 enables automatic compare
// - bit 4: clear less-than, set greater-equal
// - result high holds upper two bits
// - result high reads zero in 8-bit mode
// - results load unless compare enabled and false
// - 10-bit: high read blocks until low read
// - conversion finishing while blocked is discarded
// - 8-bit mode has no read interlock
// - result low holds low eight bits
// - 10-bit compare uses compare-high two bits
// - compare-low eight bits always compared
// - 8-bit compare ignores compare-high register
// - complete flag per compare; cleared by write/read
// - mode 00 is 8-bit, 10 is 10-bit
// - control-one write aborts; in software trigger mode restarts unless channel all ones
package adc_ctrl_pkg;
  localparam logic [7:0] OFS_CTRL_ONE   = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO   = 8'h04;
  localparam logic [7:0] OFS_RES_HIGH   = 8'h08;
  localparam logic [7:0] OFS_RES_LOW    = 8'h0C;
  localparam logic [7:0] OFS_CMP_HIGH   = 8'h10;
  localparam logic [7:0] OFS_CMP_LOW    = 8'h14;
  localparam logic [7:0] OFS_CONFIG     = 8'h18;
  localparam int         BIT_ACTIVE     = 7;
  localparam int         BIT_TRIG_SEL   = 6;
  localparam int         BIT_CMP_EN     = 5;
  localparam int         BIT_CMP_GE     = 4;
  localparam int         BIT_COMPLETE   = 7;
  localparam int         MODE_LSB       = 2;
  localparam logic [1:0] MODE_8BIT      = 2'h0;
  localparam logic [1:0] MODE_10BIT     = 2'h2;
  localparam logic [4:0] CHAN_OFF       = 5'h1F;
  localparam logic [7:0] RST_CTRL_ONE   = 8'h1F;
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam int         CONV_CYCLES    = 23;
endpackage

/* File: verilog/sar_engine.sv */
`timescale 1ns/10ps
// stand-in for the analog successive approximation: counts a fixed time, then yields the sample
module sar_engine
  import adc_ctrl_pkg::*;
#(
  parameter int CYCLES = CONV_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // control
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [9:0] sample,
  // result
  output logic            done,
  output logic [9:0]      value,
  output logic            busy
);
  logic [5:0] count_r;

  always_ff @(posedge clk) begin
    if (reset || abort) begin
      busy    <= 1'b0;
      count_r <= 6'h00;
      done    <= 1'b0;
      value   <= 10'h000;
    end else if (start) begin
      busy    <= 1'b1;
      count_r <= 6'(CYCLES - 1);
      done    <= 1'b0;
    end else if (busy && count_r == 6'h00) begin
      busy  <= 1'b0;
      done  <= 1'b1;
      value <= sample;
    end else begin
      done <= 1'b0;
      if (busy) begin
        count_r <= count_r - 6'h01;
      end
    end
  end
endmodule

/* File: verilog/adc_ctrl.sv */
// The register addresses and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/10ps
module adc_ctrl
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // converter side
  input  wire logic        hardware_trigger_input,
  input  wire logic [9:0]  analog_sample,
  output logic             conversion_in_progress_flag,
  output logic             conversion_complete_flag
);
  logic        ap_valid_r;
  logic        ap_write_r;
  logic [7:0]  ap_addr_r;
  logic [7:0]  ctrl_one_r;
  logic [7:0]  ctrl_two_r;
  logic [7:0]  cmp_high_r;
  logic [7:0]  cmp_low_r;
  logic [7:0]  config_r;
  logic [9:0]  result_r;
  logic        locked_r;
  logic [2:0]  trig_sync_r;
  logic        trig_level_r;
  logic        complete_r;
  logic        wr_ctrl_one;
  logic        rd_high;
  logic        rd_low;
  logic        hw_edge;
  logic        start;
  logic        abort;
  logic        done;
  logic [9:0]  value;
  logic        busy;
  logic        ten_bit;
  logic        cmp_ge;
  logic        cmp_true;
  logic        accept;
  logic [9:0]  cmp_val;
  logic [9:0]  eff_val;
  logic [7:0]  rd_byte;

  // writes finish in one data-phase cycle; reads take two
  always_ff @(posedge clk) begin
    if (reset) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r  <= 8'h00;
    end else if (hready) begin
      ap_valid_r <= hsel && htrans[1];
      ap_write_r <= hwrite;
      ap_addr_r  <= haddr;
    end
  end

  assign wr_ctrl_one = ap_valid_r && ap_write_r && ap_addr_r == OFS_CTRL_ONE;
  assign rd_high     = ap_valid_r && !ap_write_r && ap_addr_r == OFS_RES_HIGH;
  assign rd_low      = ap_valid_r && !ap_write_r && ap_addr_r == OFS_RES_LOW;
  assign ten_bit     = config_r[MODE_LSB +: 2] == MODE_10BIT;

  // software registers; bits 1:0 of control-two are stored as written, software keeps them zero
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_one_r <= RST_CTRL_ONE;
      ctrl_two_r <= RST_BYTE;
      cmp_high_r <= RST_BYTE;
      cmp_low_r  <= RST_BYTE;
      config_r   <= RST_BYTE;
    end else if (ap_valid_r && ap_write_r) begin
      case (ap_addr_r)
        OFS_CTRL_ONE: begin
          ctrl_one_r <= {3'h0, hwdata[4:0]};
        end
        OFS_CTRL_TWO: begin
          ctrl_two_r <= {1'b0, hwdata[6:0]};
        end
        OFS_CMP_HIGH: begin
          cmp_high_r <= {6'h00, hwdata[1:0]};
        end
        OFS_CMP_LOW: begin
          cmp_low_r <= hwdata[7:0];
        end
        OFS_CONFIG: begin
          config_r <= {4'h0, hwdata[3:2], 2'h0};
        end
        default: begin
        end
      endcase
    end
  end

  // pin input: three flops, a change counts once the last two agree
  always_ff @(posedge clk) begin
    if (reset) begin
      trig_sync_r  <= 3'h0;
      trig_level_r <= 1'b0;
    end else begin
      trig_sync_r <= {trig_sync_r[1:0], hardware_trigger_input};
      if (trig_sync_r[2] == trig_sync_r[1]) begin
        trig_level_r <= trig_sync_r[2];
      end
    end
  end

  assign hw_edge = trig_sync_r[2] && trig_sync_r[1] && !trig_level_r;
  // a write aborts whatever runs; restart only if the channel is not all ones
  assign abort   = wr_ctrl_one;
  assign start   = ctrl_two_r[BIT_TRIG_SEL]
                   ? hw_edge && ctrl_one_r[4:0] != CHAN_OFF
                   : wr_ctrl_one && hwdata[4:0] != CHAN_OFF;

  sar_engine #(
    .CYCLES (CONV_CYCLES)
  ) u_sar (
    .clk    (clk),
    .reset  (reset),
    .start  (start),
    .abort  (abort && !start),
    .sample (analog_sample),
    .done   (done),
    .value  (value),
    .busy   (busy)
  );

  // 8-bit mode keeps only the upper eight sample bits and drops the upper compare bits
  assign eff_val  = ten_bit ? value : {2'h0, value[9:2]};
  assign cmp_val  = ten_bit ? {cmp_high_r[1:0], cmp_low_r} : {2'h0, cmp_low_r};
  assign cmp_ge   = eff_val >= cmp_val;
  assign cmp_true = ctrl_two_r[BIT_CMP_GE] ? cmp_ge : !cmp_ge;
  assign accept   = done && (!ctrl_two_r[BIT_CMP_EN] || cmp_true);

  // results; while locked a finished conversion is simply lost
  always_ff @(posedge clk) begin
    if (reset) begin
      result_r <= 10'h000;
    end else if (accept && !(ten_bit && locked_r)) begin
      result_r <= eff_val;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !ten_bit) begin
      locked_r <= 1'b0;
    end else if (rd_low) begin
      locked_r <= 1'b0;
    end else if (rd_high) begin
      locked_r <= 1'b1;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      complete_r <= 1'b0;
    end else if (accept) begin
      complete_r <= 1'b1;
    end else if (wr_ctrl_one || rd_low) begin
      complete_r <= 1'b0;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    case (ap_addr_r)
      OFS_CTRL_ONE: rd_byte = {complete_r, 2'h0, ctrl_one_r[4:0]};
      OFS_CTRL_TWO: rd_byte = {busy, ctrl_two_r[6:0]};
      OFS_RES_HIGH: rd_byte = ten_bit ? {6'h00, result_r[9:8]} : 8'h00;
      OFS_RES_LOW:  rd_byte = result_r[7:0];
      OFS_CMP_HIGH: rd_byte = cmp_high_r;
      OFS_CMP_LOW:  rd_byte = cmp_low_r;
      OFS_CONFIG:   rd_byte = config_r;
      default:      rd_byte = 8'h00;
    endcase
  end

  // read data is registered, so every read stretches its data phase by one wait state
  always_ff @(posedge clk) begin
    if (reset) begin
      hrdata                      <= 32'h0000_0000;
      hreadyout                   <= 1'b1;
      hresp                       <= 1'b0;
      conversion_in_progress_flag <= 1'b0;
      conversion_complete_flag    <= 1'b0;
    end else begin
      hreadyout                   <= !(hsel && htrans[1] && !hwrite && hready);
      if (ap_valid_r && !ap_write_r) begin
        hrdata <= {24'h000000, rd_byte};
      end
      hresp                       <= 1'b0;
      conversion_in_progress_flag <= start || (busy && !abort && !done);
      conversion_complete_flag    <= complete_r;
    end
  end
endmodule

/* File: tb/adc_ctrl_asserts.sv */
`timescale 1ns/10ps
module adc_ctrl_asserts
  import adc_ctrl_pkg::*;
(
  // clock, reset, bus
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // converter
  input wire logic        hardware_trigger_input,
  input wire logic        conversion_in_progress_flag,
  input wire logic        conversion_complete_flag
);
  logic       rd_r, wr_r, trg_r, off_r;
  logic [7:0] ad_r;
  wire take = hsel & htrans[1] & hready;
  wire w1   = wr_r & hready & (ad_r == OFS_CTRL_ONE);
  wire off  = hwdata[4:0] == CHAN_OFF;
  wire act  = conversion_in_progress_flag;
  // track the data phase so writes are judged with their hwdata
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
    end else if (hready) begin
      rd_r <= take & ~hwrite;
      wr_r <= take & hwrite;
      ad_r <= haddr;
    end
  end
  always_ff @(posedge clk) begin
    if (reset)
      trg_r <= 1'b0;
    else if (wr_r & hready & (ad_r == OFS_CTRL_TWO))
      trg_r <= hwdata[BIT_TRIG_SEL];
  end
  // channel all ones also mutes the hardware trigger
  always_ff @(posedge clk) begin
    if (reset)
      off_r <= 1'b1;
    else if (w1)
      off_r <= off;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence read_wait_s;
    !hreadyout ##1 hreadyout;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0) else $error("error response seen");
  a_read_wait: assert property (take && !hwrite |=> read_wait_s) else $error("read wait wrong");
  a_write_fast: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
  a_sw_start: assert property (w1 && !trg_r && !off |-> ##[1:3] act) else $error("no start");
  a_chan_off: assert property (w1 && off |-> ##[1:3] !act) else $error("no abort");
  a_read_ends: assert property (rd_r |-> ##[0:1] hreadyout) else $error("read never ends");
  a_hw_start: assert property ($rose(hardware_trigger_input) && trg_r && !off_r && !act |-> ##[1:5] act)
    else $error("no trigger start");
  a_done_clear: assert property (w1 |-> ##[1:2] !conversion_complete_flag) else $error("flag kept");
  a_done_idle: assert property ($rose(conversion_complete_flag) |-> ##[0:1] !act) else $error("busy at end");
  a_active_ends: assert property ($rose(act) |-> ##[1:40] !act) else $error("busy stuck");
endmodule

bind adc_ctrl adc_ctrl_asserts u_chk (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hardware_trigger_input(hardware_trigger_input),
  .conversion_in_progress_flag(conversion_in_progress_flag),
  .conversion_complete_flag(conversion_complete_flag));

/* File: tb/test_adc_compare_result_control.sv */
`timescale 1ns/10ps
module test_adc_compare_result_control
  import adc_ctrl_pkg::*;
;
  logic        clk, reset, hsel, hwrite, trig, act, done, hreadyout, hresp, m, ge, e;
  logic [1:0]  htrans;
  logic [7:0]  haddr;
  logic [9:0]  smp, s, v, a;
  logic [31:0] hwdata, hrdata, q;
  logic [7:0]  ra[5] = '{OFS_CTRL_ONE, OFS_CTRL_TWO, OFS_RES_HIGH, OFS_RES_LOW, 8'h1C};
  int          fail_count, n_tests;
  adc_ctrl DUT (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .hardware_trigger_input(trig), .analog_sample(smp),
    .conversion_in_progress_flag(act), .conversion_complete_flag(done));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tmo(int k);
    if (k >= 60) begin
      chk("wait", 0, 1);
      results();
    end
  endtask
  task automatic rdy();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 60);
    tmo(k);
  endtask
  // single word transfer; address phase held until hready, then data phase
  task automatic bus(logic w, logic [7:0] ad, logic [31:0] d);
    hsel <= 1'b1;
    haddr <= ad;
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask
  task automatic idle();
    int k;
    k = 0;
    // the hardware trigger needs three sync stages before the busy flag rises
    repeat (6) @(posedge clk);
    while (act !== 1'b0 && k < 60) begin
      @(posedge clk);
      k++;
    end
    tmo(k);
    // the complete flag lands one edge after busy drops
    @(posedge clk);
  endtask
  task automatic conv(logic [9:0] x);
    smp <= x;
    bus(1'b1, OFS_CTRL_ONE, 32'h0);
    idle();
  endtask
  function automatic logic [7:0] res(logic [9:0] x, logic w10);
    return w10 ? x[7:0] : x[9:2];
  endfunction
  function automatic logic hit(logic [9:0] x, logic [9:0] c, logic g, logic w10);
    logic [9:0] r;
    r = w10 ? x : {2'h0, x[9:2]};
    c[9:8] = w10 ? c[9:8] : 2'h0;
    return g ? (r >= c) : (r < c);
  endfunction
  initial begin
    {reset, hsel, hwrite, htrans, haddr, hwdata, trig, smp} = {1'b1, 55'h0};
    fail_count = 0;
    n_tests = 0;
    void'($urandom(62));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    bus(1'b1, OFS_RES_LOW, 32'hFF);
    bus(1'b1, OFS_CTRL_TWO, 32'h80);
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 32'h0);
      chk("reset", (i == 0) ? RST_CTRL_ONE : RST_BYTE, q);
    end
    $display("test reset done");
    s = 10'($urandom);
    conv(s);
    chk("complete", 1, done);
    bus(1'b0, OFS_RES_HIGH, 32'h0);
    chk("high8", 0, q);
    bus(1'b0, OFS_RES_LOW, 32'h0);
    chk("low8", s[9:2], q);
    @(posedge clk);
    chk("clear", 0, done);
    $display("test eight done");
    bus(1'b1, OFS_CONFIG, {MODE_10BIT, 2'h0});
    a = 10'($urandom);
    conv(a);
    bus(1'b0, OFS_RES_HIGH, 32'h0);
    chk("high10", a[9:8], q);
    conv(~a);
    bus(1'b0, OFS_RES_LOW, 32'h0);
    chk("locked", a[7:0], q);
    conv(~a);
    bus(1'b0, OFS_RES_LOW, 32'h0);
    chk("unlocked", res(~a, 1), q);
    bus(1'b1, OFS_CONFIG, 32'h0);
    bus(1'b0, OFS_RES_HIGH, 32'h0);
    conv(a);
    bus(1'b0, OFS_RES_LOW, 32'h0);
    chk("nolock", a[9:2], q);
    $display("test interlock done");
    for (int i = 0; i < 16; i++) begin
      {ge, m} = 2'(i);
      s = 10'($urandom);
      v = (i < 4) ? (m ? s : {s[1:0], s[9:2]}) : 10'($urandom);
      bus(1'b1, OFS_CONFIG, m ? {MODE_10BIT, 2'h0} : 32'h0);
      bus(1'b1, OFS_CMP_HIGH, v[9:8]);
      bus(1'b1, OFS_CMP_LOW, v[7:0]);
      bus(1'b1, OFS_CTRL_TWO, 32'h0);
      conv(~s);
      bus(1'b0, OFS_RES_LOW, 32'h0);
      bus(1'b1, OFS_CTRL_TWO, {ge, 4'h0} | 32'h20);
      bus(1'b0, OFS_CTRL_TWO, 32'h0);
      chk("ctrl_two", {ge, 4'h0} | 32'h20, q);
      conv(s);
      e = hit(s, v, ge, m);
      chk("cmpflag", e, done);
      bus(1'b0, OFS_RES_LOW, 32'h0);
      chk("cmpres", e ? res(s, m) : res(~s, m), q);
    end
    $display("test compare done");
    bus(1'b1, OFS_CTRL_TWO, 32'h40);
    idle();
    smp <= ~a;
    trig <= 1'b1;
    idle();
    trig <= 1'b0;
    chk("hwdone", 1, done);
    bus(1'b0, OFS_RES_LOW, 32'h0);
    chk("hwres", res(~a, 1), q);
    bus(1'b1, OFS_CTRL_TWO, 32'h0);
    smp <= a;
    bus(1'b1, OFS_CTRL_ONE, 32'h0);
    bus(1'b1, OFS_CTRL_ONE, CHAN_OFF);
    repeat (40) @(posedge clk);
    chk("abort", 0, act);
    bus(1'b0, OFS_RES_LOW, 32'h0);
    chk("noresult", res(~a, 1), q);
    $display("test trigger done");
    results();
  end
endmodule
